// [hw/raf_flow_ctrl.sv]
// receive automatic flow control: pause frames and backpressure jamming
`timescale 1ns/100ps
module raf_flow_ctrl
   import raf_pkg::*;
#(
   parameter int unsigned JAM_CYC_PER_US = CORE_CLK_MHZ
)
(
   input  wire logic               I_CORE_CLK,
   input  wire logic               I_SYS_RST,
   // register bus
   input  wire logic               I_HSEL,
   input  wire logic [31:0]        I_HADDR,
   input  wire logic [1:0]         I_HTRANS,
   input  wire logic               I_HWRITE,
   input  wire logic [2:0]         I_HSIZE,
   input  wire logic [31:0]        I_HWDATA,
   input  wire logic               I_HREADY,
   output logic [31:0]             O_HRDATA,
   output logic                    O_HREADYOUT,
   output logic                    O_HRESP,
   // receive side
   input  wire logic [LEVEL_W-1:0] I_RX_FIFO_LEVEL,
   input  wire logic               I_RX_PREAMBLE,
   input  wire logic               I_RX_ADDR_VALID,
   input  wire logic               I_RX_MULTICAST,
   input  wire logic               I_RX_BROADCAST,
   input  wire logic               I_RX_OWN_ADDRESS,
   // MAC mode and transmit side
   input  wire logic               I_FULL_DUPLEX,
   input  wire logic               I_SPEED_100,
   input  wire logic               I_TX_ENABLE,
   input  wire logic [15:0]        I_PAUSE_TIME_VALUE,
   input  wire logic               I_PAUSE_DONE,
   output logic                    O_PAUSE_REQ,
   output logic [15:0]             O_PAUSE_TIME,
   output logic                    O_JAM
);
   //------------------------------------------------------------------
   // state
   //------------------------------------------------------------------
   typedef struct packed {
      logic [7:0]    flow_high_level;
      logic [7:0]    flow_low_level;
      logic [3:0]    jam_duration;
      logic          flow_on_multicast;
      logic          flow_on_broadcast;
      logic          flow_on_own_address;
      logic          flow_on_any_frame;
      raf_fc_state_t fc;
      logic          pause_req;
      logic [15:0]   pause_time;
      logic          pause_sent;
      logic          jam_start;
   } raf_top_st_t;

   raf_top_st_t        st;
   raf_top_st_t        next_st;

   logic               wr_en;
   logic [31:0]        bus_addr;
   logic [31:0]        rd_data;
   logic [LEVEL_W-1:0] hi_bytes;
   logic [LEVEL_W-1:0] lo_bytes;
   logic               at_high;
   logic               below_low;
   logic               auto_en;
   logic               fd_on;
   logic               fd_go;
   logic               hd_go;
   logic               addr_match;
   logic               jam_trig;
   logic               jam_abort;
   logic               jam_busy;

   //------------------------------------------------------------------
   // bus slave
   //------------------------------------------------------------------
   raf_ahb_slave u_bus (
      .i_clk       (I_CORE_CLK),
      .i_rst       (I_SYS_RST),
      .i_hsel      (I_HSEL),
      .i_haddr     (I_HADDR),
      .i_htrans    (I_HTRANS),
      .i_hwrite    (I_HWRITE),
      .i_hsize     (I_HSIZE),
      .i_hready    (I_HREADY),
      .i_rd_data   (rd_data),
      .o_hreadyout (O_HREADYOUT),
      .o_hresp     (O_HRESP),
      .o_hrdata    (O_HRDATA),
      .o_wr_en     (wr_en),
      .o_addr      (bus_addr)
   );

   //------------------------------------------------------------------
   // level compare
   //------------------------------------------------------------------
   // levels scaled to bytes
   assign hi_bytes = {1'b0, st.flow_high_level, 6'h00};
   assign lo_bytes = {1'b0, st.flow_low_level, 6'h00};
   assign at_high   = I_RX_FIFO_LEVEL >= hi_bytes;
   assign below_low = I_RX_FIFO_LEVEL < lo_bytes;

   //------------------------------------------------------------------
   // mode qualifiers
   //------------------------------------------------------------------
   assign auto_en = st.flow_on_any_frame | st.flow_on_multicast
                  | st.flow_on_broadcast | st.flow_on_own_address;
   assign fd_on = I_FULL_DUPLEX && st.flow_on_any_frame;
   assign fd_go = fd_on && I_TX_ENABLE;
   assign hd_go = !I_FULL_DUPLEX && I_TX_ENABLE && at_high;
   assign addr_match = !st.flow_on_any_frame
      && ((st.flow_on_multicast && I_RX_MULTICAST)
       || (st.flow_on_broadcast && I_RX_BROADCAST)
       || (st.flow_on_own_address && I_RX_OWN_ADDRESS));
   assign jam_trig = hd_go
      && ((st.flow_on_any_frame && I_RX_PREAMBLE)
       || (I_RX_ADDR_VALID && addr_match));
   assign jam_abort = I_FULL_DUPLEX || !I_TX_ENABLE;

   //------------------------------------------------------------------
   // jam timer
   //------------------------------------------------------------------
   // jam for programmed time
   raf_jam_timer #(
      .CYC_PER_US (JAM_CYC_PER_US)
   ) u_jam (
      .i_clk       (I_CORE_CLK),
      .i_rst       (I_SYS_RST),
      .i_start     (st.jam_start),
      .i_abort     (jam_abort),
      .i_code      (st.jam_duration),
      .i_speed_100 (I_SPEED_100),
      .o_busy      (jam_busy)
   );

   //------------------------------------------------------------------
   // register read mux
   //------------------------------------------------------------------
   always_comb begin
      case (bus_addr)
         CFG_OFFSET: begin
            rd_data = {8'h00, st.flow_high_level, st.flow_low_level,
                       st.jam_duration, st.flow_on_multicast,
                       st.flow_on_broadcast, st.flow_on_own_address,
                       st.flow_on_any_frame};
         end
         STAT_OFFSET: begin
            rd_data = {24'h00_0000, st.fc, st.pause_req, jam_busy,
                       st.pause_sent, at_high};
         end
         default: begin
            rd_data = 32'h0000_0000;   // unmapped reads as zero
         end
      endcase
   end

   //------------------------------------------------------------------
   // next state
   //------------------------------------------------------------------
   always_comb begin
      next_st = st;
      // config write
      if (wr_en && bus_addr == CFG_OFFSET) begin
         next_st.flow_high_level     = I_HWDATA[HI_LSB +: 8];
         next_st.flow_low_level      = I_HWDATA[LO_LSB +: 8];
         next_st.jam_duration        = I_HWDATA[DUR_LSB +: 4];
         next_st.flow_on_multicast   = I_HWDATA[MULT_BIT];
         next_st.flow_on_broadcast   = I_HWDATA[BRD_BIT];
         next_st.flow_on_own_address = I_HWDATA[OWN_BIT];
         next_st.flow_on_any_frame   = I_HWDATA[ANY_BIT];
      end
      next_st.jam_start = jam_trig && !jam_busy;
      // full-duplex pause sequencer
      case (st.fc)
         FC_IDLE: begin
            next_st.pause_sent = 1'b0;
            if (fd_go && at_high) begin
               next_st.fc         = FC_XOFF;
               next_st.pause_req  = 1'b1;
               next_st.pause_time = I_PAUSE_TIME_VALUE;
            end
         end
         FC_XOFF: begin
            if (!fd_go) begin
               next_st.fc        = FC_IDLE;
               next_st.pause_req = 1'b0;
            end else if (I_PAUSE_DONE) begin
               next_st.fc         = FC_PAUSED;
               next_st.pause_req  = 1'b0;
               next_st.pause_sent = 1'b1;
            end
         end
         FC_PAUSED: begin
            if (!fd_on) begin
               next_st.fc         = FC_IDLE;
               next_st.pause_sent = 1'b0;
            end else if (I_TX_ENABLE && below_low) begin
               next_st.fc         = FC_XON;
               next_st.pause_req  = 1'b1;
               next_st.pause_time = 16'h0000;
            end
         end
         FC_XON: begin
            if (!fd_go) begin
               next_st.fc        = FC_PAUSED;
               next_st.pause_req = 1'b0;
            end else if (I_PAUSE_DONE) begin
               next_st.fc         = FC_IDLE;
               next_st.pause_req  = 1'b0;
               next_st.pause_sent = 1'b0;
            end
         end
         default: begin
            next_st.fc         = FC_IDLE;
            next_st.pause_req  = 1'b0;
            next_st.pause_sent = 1'b0;
         end
      endcase
   end

   //------------------------------------------------------------------
   // state register
   //------------------------------------------------------------------
   always_ff @(posedge I_CORE_CLK) begin
      if (I_SYS_RST) begin
         st    <= '0;
         st.fc <= FC_IDLE;
         {st.flow_high_level, st.flow_low_level, st.jam_duration,
          st.flow_on_multicast, st.flow_on_broadcast,
          st.flow_on_own_address, st.flow_on_any_frame}
            <= CFG_RESET[23:0];
      end else begin
         st <= next_st;
      end
   end

   assign O_PAUSE_REQ  = st.pause_req;
   assign O_PAUSE_TIME = st.pause_time;
   assign O_JAM        = jam_busy;

   //------------------------------------------------------------------
   // checks
   //------------------------------------------------------------------
   default clocking @(posedge I_CORE_CLK); endclocking
   default disable iff (I_SYS_RST);

   sequence s_xoff_start;
      st.fc == FC_IDLE && fd_go && at_high;
   endsequence

   sequence s_xoff_done;
      st.fc == FC_XOFF && fd_go && I_PAUSE_DONE;
   endsequence

   property p_hi_trig;
      s_xoff_start |=> O_PAUSE_REQ
         && O_PAUSE_TIME == $past(I_PAUSE_TIME_VALUE);
   endproperty
   a_hi_trig: assert property (p_hi_trig)
      else $error("no pause request at the high level");

   property p_one_pause;
      s_xoff_done |=> !O_PAUSE_REQ && st.pause_sent
         ##1 (!O_PAUSE_REQ || O_PAUSE_TIME == 16'h0000);
   endproperty
   a_one_pause: assert property (p_one_pause)
      else $error("a second non-zero pause followed the first");

   property p_xon;
      st.fc == FC_PAUSED && fd_go && below_low |=> O_PAUSE_REQ
         && O_PAUSE_TIME == 16'h0000;
   endproperty
   a_xon: assert property (p_xon)
      else $error("no zero-time pause below the low level");

   // entry into the resume state only, so a later config write is legal
   property p_xon_needs;
      st.fc != FC_XON ##1 st.fc == FC_XON
         |-> st.pause_sent && $past(st.flow_on_any_frame);
   endproperty
   a_xon_needs: assert property (p_xon_needs)
      else $error("zero-time pause without an earlier pause");

   property p_tx_off;
      !I_TX_ENABLE |=> !O_PAUSE_REQ && !O_JAM && !st.jam_start;
   endproperty
   a_tx_off: assert property (p_tx_off)
      else $error("pause or jam while the transmitter is off");

   property p_fd_nojam;
      I_FULL_DUPLEX |=> !O_JAM;
   endproperty
   a_fd_nojam: assert property (p_fd_nojam)
      else $error("jam applied in full duplex");

   property p_mcast;
      hd_go && I_RX_ADDR_VALID && !st.flow_on_any_frame && !jam_busy
         && st.flow_on_multicast && I_RX_MULTICAST |=> st.jam_start;
   endproperty
   a_mcast: assert property (p_mcast)
      else $error("multicast frame not jammed");

   property p_bcast;
      hd_go && I_RX_ADDR_VALID && !st.flow_on_any_frame && !jam_busy
         && st.flow_on_broadcast && I_RX_BROADCAST |=> st.jam_start;
   endproperty
   a_bcast: assert property (p_bcast)
      else $error("broadcast frame not jammed");

   property p_own;
      hd_go && I_RX_ADDR_VALID && !st.flow_on_any_frame && !jam_busy
         && st.flow_on_own_address && I_RX_OWN_ADDRESS |=> st.jam_start;
   endproperty
   a_own: assert property (p_own)
      else $error("own-address frame not jammed");

   property p_any;
      hd_go && st.flow_on_any_frame && I_RX_PREAMBLE && !jam_busy
         |=> st.jam_start ##1 (O_JAM || $past(jam_abort));
   endproperty
   a_any: assert property (p_any)
      else $error("any-frame mode did not jam at the preamble");

   property p_override;
      st.flow_on_any_frame && !I_RX_PREAMBLE |=> !st.jam_start;
   endproperty
   a_override: assert property (p_override)
      else $error("address selects acted in any-frame mode");

   property p_fd_enable;
      !st.flow_on_any_frame |=> ##1 !O_PAUSE_REQ;
   endproperty
   a_fd_enable: assert property (p_fd_enable)
      else $error("pause requested without any-frame mode");

   property p_jam_on;
      st.jam_start && !O_JAM && !jam_abort |=> O_JAM;
   endproperty
   a_jam_on: assert property (p_jam_on)
      else $error("jam did not start for a matching frame");

   property p_status;
      wr_en && bus_addr == CFG_OFFSET |=> st.flow_high_level
         == 8'($past(I_HWDATA) >> HI_LSB)
         && auto_en == (($past(I_HWDATA) & 32'h0000_000F) != 32'h0);
   endproperty
   a_status: assert property (p_status)
      else $error("config write did not reach the level compare");
endmodule // raf_flow_ctrl

// [inc/raf_pkg.sv]
// constants and types of the receive automatic flow-control block
//
// Function
// - The high level field [23:16] times 64 bytes is the trigger level.
// - In full duplex reaching it sends exactly one pause with the MAC time.
// - In half duplex each matching frame is jammed for the duration field.
// - The low level field [15:8] times 64 bytes sends a zero-time pause.
// - The zero pause follows only a sent pause and only while enabled.
// - The duration field [7:4] sets jam length and is unused in full duplex.
// - Bit 3 jams multicast frames past the level; unused in full duplex.
// - Bit 2 jams broadcast frames past the level; unused in full duplex.
// - Bit 1 jams own-address frames past the level; unused in full duplex.
// - Bit 0 acts on any frame and alone enables full-duplex pause.
// - Half duplex any-frame mode jams at the next preamble, no decode.
// - Full duplex any-frame mode requests a pause as the level is reached.
// - Bit 0 set makes bits 3 to 1 ignored.
// - With the transmitter off no pause is sent and no jam applied.
// - Duration codes 0..F give 5..600 us, plus 2.2 us at 10 Mb/s.
package raf_pkg;
   // clock
   localparam int unsigned CORE_CLK_MHZ       = 200;
   localparam int unsigned CORE_CLK_PERIOD_NS = 5;
   // register map
   localparam logic [31:0] CFG_OFFSET  = 32'h0000_00AC;
   localparam logic [31:0] STAT_OFFSET = 32'h0000_00B8;
   localparam logic [31:0] CFG_RESET   = 32'h0000_0000;
   // field positions of the config register
   localparam int HI_LSB   = 16;
   localparam int LO_LSB   = 8;
   localparam int DUR_LSB  = 4;
   localparam int MULT_BIT = 3;
   localparam int BRD_BIT  = 2;
   localparam int OWN_BIT  = 1;
   localparam int ANY_BIT  = 0;
   // widths
   localparam int LEVEL_W = 15;
   localparam int JAM_W   = 18;
   // jam durations in tenths of a microsecond at 100 Mb/s
   localparam int unsigned JAM_TENTHS_US [16] = '{
      50, 100, 150, 250, 500, 1000, 1500, 2000,
      2500, 3000, 3500, 4000, 4500, 5000, 5500, 6000};
   localparam int unsigned JAM_10M_EXTRA_TENTHS = 22;
   localparam int unsigned TENTHS_PER_US        = 10;
   // bus encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD    = 3'h2;
   // full-duplex pause sequencer
   typedef enum logic [3:0] {
      FC_IDLE   = 4'h1,
      FC_XOFF   = 4'h2,
      FC_PAUSED = 4'h4,
      FC_XON    = 4'h8
   } raf_fc_state_t;
endpackage

// [hw/raf_ahb_slave.sv]
// AHB-Lite slave front end with one wait state per transfer
`timescale 1ns/100ps
module raf_ahb_slave
   import raf_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   input  wire logic        i_hsel,
   input  wire logic [31:0] i_haddr,
   input  wire logic [1:0]  i_htrans,
   input  wire logic        i_hwrite,
   input  wire logic [2:0]  i_hsize,
   input  wire logic        i_hready,
   input  wire logic [31:0] i_rd_data,
   output logic             o_hreadyout,
   output logic             o_hresp,
   output logic [31:0]      o_hrdata,
   output logic             o_wr_en,
   output logic [31:0]      o_addr
);
   typedef struct packed {
      logic        pend;
      logic        write;
      logic [31:0] addr;
      logic        ready;
      logic [31:0] rdata;
   } raf_ahb_st_t;

   raf_ahb_st_t st;
   raf_ahb_st_t next_st;
   logic        take;

   // address phase capture, then answer one cycle later
   always_comb begin
      take    = i_hsel && i_hready && (i_htrans == HTRANS_NONSEQ);
      next_st = st;
      next_st.pend = 1'b0;
      if (st.pend) begin
         next_st.ready = 1'b1;
         next_st.rdata = st.write ? 32'h0000_0000 : i_rd_data;
      end else if (take) begin
         next_st.pend  = 1'b1;
         next_st.ready = 1'b0;
         next_st.write = i_hwrite && (i_hsize == HSIZE_WORD);
         next_st.addr  = i_haddr;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         st       <= '0;
         st.ready <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign o_hreadyout = st.ready;
   assign o_hresp     = 1'b0;   // always OKAY
   assign o_hrdata    = st.rdata;
   assign o_wr_en     = st.pend && st.write;
   assign o_addr      = st.addr;

   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);

   property p_one_wait;
      take && !st.pend |=> !o_hreadyout ##1 o_hreadyout;
   endproperty
   a_one_wait: assert property (p_one_wait)
      else $error("slave did not answer after one wait state");
endmodule // raf_ahb_slave

// [hw/raf_jam_timer.sv]
// backpressure duration timer
`timescale 1ns/100ps
module raf_jam_timer
   import raf_pkg::*;
#(
   parameter int unsigned CYC_PER_US = CORE_CLK_MHZ
)
(
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   input  wire logic       i_start,
   input  wire logic       i_abort,
   input  wire logic [3:0] i_code,
   input  wire logic       i_speed_100,
   output logic            o_busy
);
   typedef struct packed {
      logic             busy;
      logic [JAM_W-1:0] left;
   } raf_tmr_st_t;

   raf_tmr_st_t      st;
   raf_tmr_st_t      next_st;
   logic [JAM_W-1:0] load;

   always_comb begin
      load = JAM_W'(((JAM_TENTHS_US[i_code]
             + (i_speed_100 ? 0 : JAM_10M_EXTRA_TENTHS)) * CYC_PER_US)
             / TENTHS_PER_US);
      next_st = st;
      if (i_abort) begin
         next_st = '0;
      end else if (i_start && !st.busy) begin
         next_st.busy = 1'b1;
         next_st.left = load;
      end else if (st.busy) begin
         if (st.left == JAM_W'(1)) begin
            next_st.busy = 1'b0;
         end
         next_st.left = st.left - JAM_W'(1);
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign o_busy = st.busy;

   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);

   property p_jam_load;
      i_start && !st.busy && !i_abort |=> st.busy && st.left == $past(load);
   endproperty
   a_jam_load: assert property (p_jam_load)
      else $error("jam timer loaded a wrong duration");

   property p_jam_end;
      st.busy && st.left == JAM_W'(1) && !i_abort |=> !st.busy;
   endproperty
   a_jam_end: assert property (p_jam_end)
      else $error("jam did not end when its time ran out");
endmodule // raf_jam_timer

// [bench/raf_mac_model.sv]
// pause transmit model of the MAC beside the flow controller
`timescale 1ns/100ps
module raf_mac_model (
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   input  wire logic [7:0]  i_lat,
   input  wire logic        i_pause_req,
   input  wire logic [15:0] i_pause_time,
   output logic             o_pause_done,
   output int               o_frames,
   output logic [15:0]      o_last_time
);
   logic [7:0] wait_cnt;

   // queue a request, send one frame after i_lat + 1 cycles
   always @(posedge i_clk) begin
      o_pause_done <= 1'b0;
      if (i_rst) begin
         wait_cnt    <= 8'h00;
         o_frames    <= 0;
         o_last_time <= 16'hFFFF;
      end else if (i_pause_req && !o_pause_done) begin
         wait_cnt <= wait_cnt + 8'h01;
         if (wait_cnt >= i_lat) begin
            o_pause_done <= 1'b1; // one-cycle strobe
            o_frames     <= o_frames + 1;
            o_last_time  <= i_pause_time;
            wait_cnt     <= 8'h00;
         end
      end else begin
         wait_cnt <= 8'h00;
      end
   end
endmodule // raf_mac_model

// [bench/raf_flow_ctrl_tb.sv]
// self-checking bench of the receive automatic flow-control block
`timescale 1ns/100ps
module raf_flow_ctrl_tb;
   import raf_pkg::*;
   localparam int JPU = 10;
   logic        clk, rst, hsel, hwrite, pre, av, mc, bc, own;
   logic        fd, sp, tx, done, req, jam, rdy, resp;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [1:0]  htrans;
   logic [15:0] ptv, ptime, last;
   logic [14:0] lvl;
   logic [7:0]  lat;
   int          frames, num_errors, checks, cyc, n;
   int          cd [3] = '{0, 5, 15};

   raf_flow_ctrl #(.JAM_CYC_PER_US(JPU)) raf_flow_ctrl_i (
      .I_CORE_CLK(clk), .I_SYS_RST(rst), .I_HSEL(hsel), .I_HADDR(haddr),
      .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(HSIZE_WORD),
      .I_HWDATA(hwdata), .I_HREADY(rdy), .O_HRDATA(hrdata),
      .O_HREADYOUT(rdy), .O_HRESP(resp), .I_RX_FIFO_LEVEL(lvl),
      .I_RX_PREAMBLE(pre), .I_RX_ADDR_VALID(av), .I_RX_MULTICAST(mc),
      .I_RX_BROADCAST(bc), .I_RX_OWN_ADDRESS(own), .I_FULL_DUPLEX(fd),
      .I_SPEED_100(sp), .I_TX_ENABLE(tx), .I_PAUSE_TIME_VALUE(ptv),
      .I_PAUSE_DONE(done), .O_PAUSE_REQ(req), .O_PAUSE_TIME(ptime),
      .O_JAM(jam));
   raf_mac_model raf_mac_model_i (
      .i_clk(clk), .i_rst(rst), .i_lat(lat), .i_pause_req(req),
      .i_pause_time(ptime), .o_pause_done(done), .o_frames(frames),
      .o_last_time(last));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // -------------------------------------------------------------
   // shared tasks
   // -------------------------------------------------------------
   task automatic close_out;
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         num_errors++;
         $display("wrong value at %0t: saw %h want %h", $time, s, e);
      end
   endtask

   // single AHB-Lite word transfer, waits on hready at each phase
   task automatic bus(input logic w, input logic [31:0] a, d);
      hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= HTRANS_NONSEQ;
      do @(posedge clk); while (rdy !== 1'b1);
      htrans <= 2'h0; hsel <= 1'b0; hwdata <= d;
      do @(posedge clk); while (rdy !== 1'b1);
      q = hrdata;
   endtask

   function automatic logic [31:0] cfgv(input logic [7:0] hi, lo,
                                        input logic [3:0] dur, sel);
      return {8'h00, hi, lo, dur, sel};
   endfunction

   task automatic wait_req(input logic v);
      for (int k = 0; k < 60 && req !== v; k++) @(posedge clk);
      chk(req, v);
   endtask

   // one trigger, then count the cycles the jam stands
   task automatic jam_try(input logic p, input logic [2:0] cls, int e);
      if (p) pre <= 1'b1;
      else begin
         av <= 1'b1; {mc, bc, own} <= cls;
      end
      @(posedge clk);
      pre <= 1'b0; av <= 1'b0;
      n = 0;
      for (int k = 0; k < 8 && jam !== 1'b1; k++) @(posedge clk);
      while (jam === 1'b1 && n < 7000) begin
         @(posedge clk);
         n++;
      end
      chk(n, e);
      @(posedge clk);
   endtask

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         num_errors++;
         close_out;
      end
   end

   // -------------------------------------------------------------
   // main sequence
   // -------------------------------------------------------------
   initial begin
      {rst, hsel, hwrite, pre, av, mc, bc, own} = 8'hFF;
      {hsel, hwrite, pre, av, mc, bc, own, fd, sp, tx} = 10'h000;
      haddr = 32'h0; hwdata = 32'h0; htrans = 2'h0; ptv = 16'h1234;
      lvl = 15'h0000; lat = 8'h06; num_errors = 0; checks = 0; cyc = 0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      bus(1'b0, CFG_OFFSET, 32'h0);
      chk(q, CFG_RESET);
      bus(1'b1, CFG_OFFSET, 32'hFFFF_FEFF);
      bus(1'b0, CFG_OFFSET, 32'h0);
      chk(q, 32'h00FF_FEFF);
      chk(resp, 1'b0);
      bus(1'b1, 32'h0000_0040, 32'h0);
      bus(1'b0, 32'h0000_0040, 32'h0);
      chk(q, 32'h0);
      $display("register test done");
      fd <= 1'b1; tx <= 1'b1; lvl <= 15'h00C8;
      bus(1'b1, CFG_OFFSET, cfgv(8'h02, 8'h01, 4'h0, 4'hE));
      jam_try(1'b0, 3'h7, 0);
      chk(req, 1'b0);
      lvl <= 15'h0000;
      bus(1'b1, CFG_OFFSET, cfgv(8'h02, 8'h01, 4'h0, 4'h1));
      repeat (6) @(posedge clk);
      chk(req, 1'b0);
      lvl <= 15'h0080;
      wait_req(1'b1);
      chk(ptime, 16'h1234);
      wait_req(1'b0);
      repeat (30) @(posedge clk);
      chk(frames, 1);
      bus(1'b0, STAT_OFFSET, 32'h0);
      chk(q, 32'h0000_0043);
      lat <= 8'h00; lvl <= 15'h0040;
      repeat (8) @(posedge clk);
      chk(req, 1'b0);
      lvl <= 15'h003F;
      wait_req(1'b1);
      chk(ptime, 16'h0000);
      wait_req(1'b0);
      chk(frames, 2);
      $display("full duplex test done");
      fd <= 1'b0; lvl <= 15'h00C8;
      for (int i = 0; i < 6; i++) begin
         sp <= i[0];
         bus(1'b1, CFG_OFFSET, cfgv(8'h02, 8'h01, cd[i/2][3:0], 4'h1));
         jam_try(1'b1, 3'h0, (JAM_TENTHS_US[cd[i/2]] + (i[0] ? 0 :
                 JAM_10M_EXTRA_TENTHS)) * JPU / TENTHS_PER_US);
      end
      jam_try(1'b0, 3'h4, 0);
      sp <= 1'b1;
      for (int b = 1; b < 4; b++) begin
         logic [3:0] sel;
         sel = 4'(4'h1 << b);
         bus(1'b1, CFG_OFFSET, cfgv(8'h02, 8'h01, 4'h0, sel));
         jam_try(1'b0, {sel[2:1], sel[3]}, 0);
         jam_try(1'b0, sel[3:1], JAM_TENTHS_US[0] * JPU / 10);
      end
      $display("half duplex test done");
      tx <= 1'b0;
      bus(1'b1, CFG_OFFSET, cfgv(8'h02, 8'h01, 4'h0, 4'h1));
      jam_try(1'b1, 3'h0, 0);
      fd <= 1'b1;
      repeat (12) @(posedge clk);
      chk(req, 1'b0);
      $display("transmitter off test done");
      close_out;
   end
endmodule // raf_flow_ctrl_tb
